// file: design/frtc_pkg.sv
// =============================================================
// Shared constants of the free-running timer.
package frtc_pkg;
  // Register byte addresses on the APB.
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h00;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;
  localparam logic [7:0] ADDR_STATUS = 8'h08;
  localparam logic [7:0] ADDR_CNT_HI = 8'h0c;
  localparam logic [7:0] ADDR_CNT_LO = 8'h10;
  localparam logic [7:0] ADDR_ALT_HI = 8'h14;
  localparam logic [7:0] ADDR_ALT_LO = 8'h18;
  localparam logic [7:0] ADDR_CAP1_HI = 8'h1c;
  localparam logic [7:0] ADDR_CAP1_LO = 8'h20;
  localparam logic [7:0] ADDR_CAP2_HI = 8'h24;
  localparam logic [7:0] ADDR_CAP2_LO = 8'h28;
  // Control one fields.
  localparam int BIT_OVF_IE = 0;
  localparam int BIT_CAP_IE = 1;
  localparam int BIT_EDGE1 = 2;
  // Control two fields.
  localparam int BIT_CSEL_LO = 0;
  localparam int BIT_EXT_EDGE = 2;
  localparam int BIT_EDGE2 = 3;
  localparam int BIT_OPM = 4;
  localparam int BIT_PWM = 5;
  // Status fields.
  localparam int BIT_OVF = 0;
  localparam int BIT_CF1 = 1;
  localparam int BIT_CF2 = 2;
  // Reset and reload count, and the wrap point.
  localparam logic [15:0] COUNT_RELOAD = 16'hfffc;
  localparam logic [15:0] COUNT_TOP = 16'hffff;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  // Clock select encodings.
  localparam logic [1:0] CSEL_DIV2 = 2'h0;
  localparam logic [1:0] CSEL_DIV4 = 2'h1;
  localparam logic [1:0] CSEL_DIV8 = 2'h2;
  localparam logic [1:0] CSEL_EXT = 2'h3;
endpackage

// file: design/frtc_edge.sv
// =============================================================
// Pin synchroniser with selectable edge detection.
module frtc_edge
  import frtc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Pin and edge choice.
  input wire logic pin,
  input wire logic rise_sel,
  // One-cycle pulse on the chosen edge.
  output logic hit
);
  // First stage feeds only the second stage.
  logic sync1_q;
  // Second stage, safe to read.
  logic sync2_q;
  // Previous synchronised level for edge detection.
  logic prev_q;

  // Two flip-flops guard against metastability, then one more for history.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end

  // Rising or falling transition, as selected.
  assign hit = rise_sel ? (sync2_q & ~prev_q) : (~sync2_q & prev_q);
endmodule // frtc_edge

// file: design/frtc_capture.sv
// =============================================================
// One input-capture channel with its flag and read lock.
module frtc_capture
  import frtc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // Capture event and permission.
  input wire logic hit,
  input wire logic enable,
  input wire logic [15:0] count,
  // Register access strobes.
  input wire logic rd_high,
  input wire logic acc_low,
  input wire logic arm_set,
  // Captured value and flag.
  output logic [15:0] value_q,
  output logic flag_q
);
  // Set by a high byte read, released by the low byte access.
  logic lock_q;
  // First clearing step seen.
  logic arm_q;
  // A capture that is actually taken.
  logic take;

  assign take = hit & enable & ~lock_q;

  // Latch, flag and lock; a new capture wins over a clear in the same cycle.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      value_q <= 16'h0000;
      flag_q <= 1'b0;
      lock_q <= 1'b0;
      arm_q <= 1'b0;
    end
    else
    begin
      if (take)
        value_q <= count;
      if (take)
        flag_q <= 1'b1;
      else if (arm_q && acc_low)
        flag_q <= 1'b0;
      lock_q <= rd_high | (lock_q & ~acc_low);
      arm_q <= arm_set | (arm_q & ~acc_low);
    end
  end
endmodule // frtc_capture

// file: design/frtc_timer.sv
// =============================================================
// Free-running 16-bit timer with two capture channels, APB slave.
module frtc_timer
  import frtc_pkg::*;
(
  // Clock and reset.
  input wire logic pclk,
  input wire logic presetn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // CPU side levels on this clock.
  input wire logic cpu_irq_mask,
  input wire logic halt_mode,
  // Timer pins.
  input wire logic ext_count_clock_pin,
  input wire logic capture_pin1,
  input wire logic capture_pin2,
  // Timer interrupt request.
  output logic timer_irq
);
  // =============================================================
  // State
  // Software control registers.
  logic [7:0] control_reg_one_q;
  logic [7:0] control_reg_two_q;
  // Live count and its next value.
  logic [15:0] count_q;
  logic [15:0] count_d;
  // Low byte buffer for the 16-bit read sequence.
  logic [7:0] cnt_buf_q;
  logic cnt_lock_q;
  // Overflow flag and first clear step.
  logic overflow_flag_q;
  logic ovf_arm_q;
  // Free-running prescaler.
  logic [2:0] div_q;
  // Registered bus answer.
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  logic timer_irq_q;

  // =============================================================
  // Bus decode
  // Setup phase, when the answer is prepared.
  wire setup = psel & ~penable;
  // Access edge, where effects happen.
  wire access = psel & penable & pready_q;
  wire rd = access & ~pwrite;
  wire wr = access & pwrite;
  wire hit_ctl1 = paddr == ADDR_CTRL_ONE;
  wire hit_ctl2 = paddr == ADDR_CTRL_TWO;
  wire hit_stat = paddr == ADDR_STATUS;
  wire hit_chi = paddr == ADDR_CNT_HI;
  wire hit_clo = paddr == ADDR_CNT_LO;
  wire hit_ahi = paddr == ADDR_ALT_HI;
  wire hit_alo = paddr == ADDR_ALT_LO;
  wire hit_c1h = paddr == ADDR_CAP1_HI;
  wire hit_c1l = paddr == ADDR_CAP1_LO;
  wire hit_c2h = paddr == ADDR_CAP2_HI;
  wire hit_c2l = paddr == ADDR_CAP2_LO;
  wire mapped = hit_ctl1 | hit_ctl2 | hit_stat | hit_chi | hit_clo | hit_ahi | hit_alo |
                hit_c1h | hit_c1l | hit_c2h | hit_c2l;

  // Control fields.
  wire [1:0] clock_select_field = control_reg_two_q[BIT_CSEL_LO +: 2];
  wire ext_clock_edge_select = control_reg_two_q[BIT_EXT_EDGE];
  wire overflow_irq_enable = control_reg_one_q[BIT_OVF_IE];
  wire capture_irq_enable = control_reg_one_q[BIT_CAP_IE];
  wire pulse_modes = control_reg_two_q[BIT_OPM] | control_reg_two_q[BIT_PWM];

  // =============================================================
  // Clock source
  // Edge pulse from the external count clock.
  logic ext_hit;
  // Internal prescaler tick.
  logic tick_int;
  // Tick that really advances the count.
  logic tick;

  frtc_edge u_ext_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(ext_count_clock_pin),
    .rise_sel(ext_clock_edge_select),
    .hit(ext_hit)
  );

  assign tick_int = (clock_select_field == CSEL_DIV2) ? div_q[0] :
                    (clock_select_field == CSEL_DIV4) ? &div_q[1:0] : &div_q;
  assign tick = ~halt_mode & ((clock_select_field == CSEL_EXT) ? ext_hit : tick_int);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_q <= 3'h0;
    else
      div_q <= div_q + 3'h1;
  end

  // =============================================================
  // Counter
  // Either low byte written reloads the count.
  wire wr_low = wr & (hit_clo | hit_alo);
  // Wrap happens when a tick meets the top value.
  wire wrap = tick & ~wr_low & (count_q == COUNT_TOP);

  assign count_d = wr_low ? COUNT_RELOAD : (tick ? count_q + 16'h0001 : count_q);

  // single-clock update
  // The count moves only on pclk, so pin edges arrive two cycles late but never glitch it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      count_q <= COUNT_RELOAD;
    else
      count_q <= count_d;
  end

  // =============================================================
  // Read buffering and overflow flag
  wire rd_cnt_high = rd & (hit_chi | hit_ahi);
  // The low byte is taken at the setup edge, where the high byte is sampled too, so a carry cannot split the pair.
  wire setup_cnt_high = setup & ~pwrite & (hit_chi | hit_ahi);
  wire rd_cnt_low = rd & (hit_clo | hit_alo);
  // Only the primary low byte counts as the second clearing step.
  wire acc_clo = access & hit_clo;
  // The first step uses the value software actually saw.
  wire stat_seen_ovf = rd & hit_stat & prdata_q[BIT_OVF];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_buf_q <= 8'h00;
      cnt_lock_q <= 1'b0;
    end
    else
    begin
      if (setup_cnt_high && !cnt_lock_q)
        cnt_buf_q <= count_q[7:0];
      cnt_lock_q <= rd_cnt_high | (cnt_lock_q & ~rd_cnt_low);
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      overflow_flag_q <= 1'b0;
      ovf_arm_q <= 1'b0;
    end
    else
    begin
      if (wrap)
        overflow_flag_q <= 1'b1;
      else if (ovf_arm_q && acc_clo)
        overflow_flag_q <= 1'b0;
      ovf_arm_q <= stat_seen_ovf | (ovf_arm_q & ~acc_clo);
    end
  end

  // =============================================================
  // Capture channels
  logic cap1_hit;
  logic cap2_hit;
  logic [15:0] cap1_q;
  logic [15:0] cap2_q;
  logic cf1;
  logic cf2;

  frtc_edge u_cap1_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_pin1),
    .rise_sel(control_reg_one_q[BIT_EDGE1]),
    .hit(cap1_hit)
  );

  frtc_edge u_cap2_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(capture_pin2),
    .rise_sel(control_reg_two_q[BIT_EDGE2]),
    .hit(cap2_hit)
  );

  frtc_capture u_cap1 (
    .pclk(pclk),
    .presetn(presetn),
    .hit(cap1_hit),
    .enable(~pulse_modes),
    .count(count_q),
    .rd_high(rd & hit_c1h),
    .acc_low(access & hit_c1l),
    .arm_set(rd & hit_stat & prdata_q[BIT_CF1]),
    .value_q(cap1_q),
    .flag_q(cf1)
  );

  frtc_capture u_cap2 (
    .pclk(pclk),
    .presetn(presetn),
    .hit(cap2_hit),
    .enable(1'b1),
    .count(count_q),
    .rd_high(rd & hit_c2h),
    .acc_low(access & hit_c2l),
    .arm_set(rd & hit_stat & prdata_q[BIT_CF2]),
    .value_q(cap2_q),
    .flag_q(cf2)
  );

  // =============================================================
  // Register writes and read mux
  // live low byte when not locked
  wire [7:0] low_view = cnt_lock_q ? cnt_buf_q : count_q[7:0];
  wire [7:0] status_view = {5'h00, cf2, cf1, overflow_flag_q};
  // both views show the same count
  wire [7:0] rd_byte = hit_ctl1 ? control_reg_one_q :
                       hit_ctl2 ? control_reg_two_q :
                       hit_stat ? status_view :
                       (hit_chi | hit_ahi) ? count_q[15:8] :
                       (hit_clo | hit_alo) ? low_view :
                       hit_c1h ? cap1_q[15:8] :
                       hit_c1l ? cap1_q[7:0] :
                       hit_c2h ? cap2_q[15:8] :
                       hit_c2l ? cap2_q[7:0] : 8'h00;

  // Control registers take the low byte lane of a write.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_reg_one_q <= CTRL_RESET;
      control_reg_two_q <= CTRL_RESET;
    end
    else
    begin
      if (wr && hit_ctl1)
        control_reg_one_q <= pwdata[7:0];
      if (wr && hit_ctl2)
        control_reg_two_q <= pwdata[7:0];
    end
  end

  // The answer is built in the setup cycle so every bus output is a flip-flop.
  // This costs no wait state: pready rises together with penable.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end
    else
    begin
      pready_q <= setup;
      pslverr_q <= setup & ~mapped;
      if (setup)
        prdata_q <= {24'h000000, pwrite ? 8'h00 : rd_byte};
    end
  end

  // shared capture enable
  // Pending flags simply wait here until the mask clears.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      timer_irq_q <= 1'b0;
    else
      timer_irq_q <= ~cpu_irq_mask & ((overflow_flag_q & overflow_irq_enable) |
                                      ((cf1 | cf2) & capture_irq_enable));
  end

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign timer_irq = timer_irq_q;

  // =============================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_reload;
    wr_low |=> count_q == COUNT_RELOAD;
  endproperty
  a_reload: assert property (p_reload) else $error("count not reloaded to fffc");

  property p_ovf_set;
    wrap |=> overflow_flag_q && count_q == 16'h0000;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("wrap did not set overflow");

  property p_alt_keeps;
    (access && hit_alo && overflow_flag_q) |=> overflow_flag_q;
  endproperty
  a_alt_keeps: assert property (p_alt_keeps) else $error("alternate low cleared overflow");

  property p_ovf_clear;
    $fell(overflow_flag_q) |-> $past(ovf_arm_q) && $past(acc_clo);
  endproperty
  a_ovf_clear: assert property (p_ovf_clear) else $error("overflow cleared without two steps");

  property p_masked;
    cpu_irq_mask |=> !timer_irq;
  endproperty
  a_masked: assert property (p_masked) else $error("interrupt raised while masked");

  property p_halt;
    (halt_mode && !wr_low) |=> $stable(count_q);
  endproperty
  a_halt: assert property (p_halt) else $error("count moved in halt");

  property p_buf_frozen;
    (cnt_lock_q && !rd_cnt_low) |=> $stable(cnt_buf_q) && cnt_lock_q;
  endproperty
  a_buf_frozen: assert property (p_buf_frozen) else $error("buffered low byte changed");

  property p_div2;
    (clock_select_field == CSEL_DIV2 && !halt_mode && !wr_low && tick) ##1
      (clock_select_field == CSEL_DIV2 && !halt_mode && !wr_low) |=> $stable(count_q);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by two ticked twice in a row");

  property p_cap1_off;
    pulse_modes |=> $stable(cap1_q) && !$rose(cf1);
  endproperty
  a_cap1_off: assert property (p_cap1_off) else $error("channel one captured in pulse mode");

  c_wrap: cover property (wrap ##[1:40] (access && hit_clo));
  c_cap2: cover property (cap2_hit ##1 cf2);
  c_ext: cover property (clock_select_field == CSEL_EXT && ext_hit);
endmodule // frtc_timer

// file: verification/frtc_pin_model.sv
// =============================================================
// Pin-side partner: external count clock and two capture inputs.
module frtc_pin_model
  import frtc_pkg::*;
(
  // Clock.
  input wire logic pclk,
  // Timer pins, all start low.
  output logic ext_pin,
  output logic cap_pin1,
  output logic cap_pin2
);
  timeunit 1ns;
  timeprecision 1ps;

  // Pins rest low until the bench asks for edges.
  initial
  begin
    ext_pin = 1'b0;
    cap_pin1 = 1'b0;
    cap_pin2 = 1'b0;
  end

  // Toggles one pin n times; pin 0 is the count clock, 1 and 2 the capture inputs.
  task automatic toggle(input int which, input int n);
    repeat (n)
    begin
      @(posedge pclk);
      if (which == 0)
        ext_pin <= ~ext_pin;
      else if (which == 1)
        cap_pin1 <= ~cap_pin1;
      else
        cap_pin2 <= ~cap_pin2;
      // edge spacing kept
      // Six clocks between toggles leave twelve between active edges, well above the minimum.
      repeat (5) @(posedge pclk);
    end
  endtask
endmodule // frtc_pin_model

// file: verification/tb_top.sv
// =============================================================
// Self-checking bench for the free-running timer.
module tb_top
  import frtc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0; // Bus clock.
  logic presetn = 1'b0; // Reset, active low.
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic cpu_irq_mask = 1'b1; // Masked until the interrupt test.
  logic halt_mode = 1'b1; // Frozen so that counts are predictable.
  logic ext_pin;
  logic cap_pin1;
  logic cap_pin2;
  logic timer_irq;
  int n_mismatch = 0;
  int tests_run = 0;
  integer seed = 32'h57023a88;
  logic [31:0] rd; // Last read data.
  logic err; // Last error response.
  logic [15:0] v; // Last 16-bit pair read.
  logic [15:0] capv; // Frozen count seen by the captures.
  logic [15:0] dv;
  int n;
  int d;
  int e;

  // =============================================================
  // Instances.
  frtc_timer frtc_timer_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cpu_irq_mask(cpu_irq_mask), .halt_mode(halt_mode),
    .ext_count_clock_pin(ext_pin), .capture_pin1(cap_pin1), .capture_pin2(cap_pin2),
    .timer_irq(timer_irq));
  frtc_pin_model frtc_pin_model_inst (.pclk(pclk), .ext_pin(ext_pin), .cap_pin1(cap_pin1),
    .cap_pin2(cap_pin2));

  // Free-running 20 MHz clock.
  initial
  begin
    forever #25 pclk = ~pclk;
  end

  // =============================================================
  // Bus and check tasks.
  // One APB transfer; the request holds until pready is seen at a rising edge.
  // Only the watchdog ends a wait that never sees pready.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdb(input logic [7:0] a);
    apb(1'b0, a, 32'h0);
  endtask

  task automatic wrb(input logic [7:0] a, input logic [31:0] wd);
    apb(1'b1, a, wd);
  endtask

  // High byte first, so the pair is coherent even on a running count.
  task automatic rd16(input logic [7:0] hi);
    rdb(hi);
    v[15:8] = rd[7:0];
    rdb(hi + 8'h04);
    v[7:0] = rd[7:0];
  endtask

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Reads status and compares one flag.
  task automatic stat(input int b, input logic x);
    rdb(ADDR_STATUS);
    chk(16'(rd[b]), 16'(x));
  endtask

  // Makes pin edges, then compares one flag once the synchroniser has settled.
  task automatic edge_stat(input int which, input int cnt, input int b, input logic x);
    frtc_pin_model_inst.toggle(which, cnt);
    stat(b, x);
  endtask

  task automatic end_sim();
    $display("checks %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Watchdog: the tests need a few thousand cycles at most.
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_mismatch++;
    end_sim();
  end

  // =============================================================
  // Main sequence.
  initial
  begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rd16(ADDR_CNT_HI);
    chk(v, COUNT_RELOAD);
    rd16(ADDR_ALT_HI);
    chk(v, COUNT_RELOAD);
    rdb(ADDR_CTRL_ONE);
    chk(rd[15:0], 16'(CTRL_RESET));
    // An unmapped place answers with an error and zero data.
    rdb(8'h2c);
    chk({rd[14:0], err}, 16'h1);
    // Run through the wrap with the request masked.
    wrb(ADDR_CTRL_ONE, 32'h1);
    halt_mode <= 1'b0;
    repeat (20) @(posedge pclk);
    halt_mode <= 1'b1;
    rdb(ADDR_CNT_LO);
    stat(BIT_OVF, 1'b1);
    chk(16'(timer_irq), 16'h0);
    cpu_irq_mask <= 1'b0;
    repeat (3) @(posedge pclk);
    chk(16'(timer_irq), 16'h1);
    rdb(ADDR_ALT_LO);
    stat(BIT_OVF, 1'b1);
    rdb(ADDR_CNT_LO);
    stat(BIT_OVF, 1'b0);
    chk(16'(timer_irq), 16'h0);
    wrb(ADDR_CNT_LO, 32'($random(seed)));
    rd16(ADDR_CNT_HI);
    chk(v, COUNT_RELOAD);
    // Buffered low byte survives a run and a second high read.
    wrb(ADDR_ALT_LO, 32'h0);
    rdb(ADDR_CNT_HI);
    chk(rd[15:0], 16'h00ff);
    halt_mode <= 1'b0;
    repeat (30) @(posedge pclk);
    halt_mode <= 1'b1;
    rdb(ADDR_CNT_HI);
    rdb(ADDR_CNT_LO);
    chk(rd[15:0], 16'h00fc);
    // The buffer now holds a low byte other than fc, so a stale buffer would show.
    rd16(ADDR_ALT_HI);
    wrb(ADDR_ALT_LO, 32'h0);
    rdb(ADDR_CNT_LO);
    chk(rd[15:0], 16'h00fc);
    // Each internal division over a random run length, one tick of slack.
    for (int c = 0; c < 3; c++)
    begin
      n = 40 + ($random(seed) & 255);
      wrb(ADDR_CTRL_TWO, 32'(c));
      wrb(ADDR_ALT_LO, 32'h0);
      halt_mode <= 1'b0;
      repeat (n) @(posedge pclk);
      halt_mode <= 1'b1;
      rd16(ADDR_ALT_HI);
      dv = v - COUNT_RELOAD;
      d = int'(dv);
      e = n >> (c + 1);
      chk(16'(d + 1 >= e && d <= e + 1), 16'h1);
    end
    // External clock: five toggles from low give three rises; four from high give two falls.
    wrb(ADDR_CTRL_TWO, 32'h7);
    wrb(ADDR_ALT_LO, 32'h0);
    halt_mode <= 1'b0;
    frtc_pin_model_inst.toggle(0, 5);
    repeat (8) @(posedge pclk);
    halt_mode <= 1'b1;
    rd16(ADDR_ALT_HI);
    chk(v, COUNT_RELOAD + 16'h3);
    wrb(ADDR_CTRL_TWO, 32'h3);
    wrb(ADDR_ALT_LO, 32'h0);
    halt_mode <= 1'b0;
    frtc_pin_model_inst.toggle(0, 4);
    repeat (8) @(posedge pclk);
    halt_mode <= 1'b1;
    rd16(ADDR_ALT_HI);
    chk(v, COUNT_RELOAD + 16'h2);
    // Freeze at a random count for the captures.
    wrb(ADDR_CTRL_TWO, 32'h0);
    halt_mode <= 1'b0;
    repeat (1 + ($random(seed) & 63)) @(posedge pclk);
    halt_mode <= 1'b1;
    rd16(ADDR_ALT_HI);
    capv = v;
    repeat (20) @(posedge pclk);
    rd16(ADDR_ALT_HI);
    chk(v, capv);
    wrb(ADDR_CTRL_ONE, 32'h6);
    // A low read before any status read must leave the flag set; the write then clears it.
    frtc_pin_model_inst.toggle(1, 1);
    rd16(ADDR_CAP1_HI);
    chk(v, capv);
    stat(BIT_CF1, 1'b1);
    chk(16'(timer_irq), 16'h1);
    wrb(ADDR_CAP1_LO, 32'h0);
    stat(BIT_CF1, 1'b0);
    edge_stat(1, 1, BIT_CF1, 1'b0);
    edge_stat(2, 1, BIT_CF2, 1'b0);
    edge_stat(2, 1, BIT_CF2, 1'b1);
    rd16(ADDR_CAP2_HI);
    chk(v, capv);
    rdb(ADDR_STATUS);
    rdb(ADDR_CAP2_LO);
    stat(BIT_CF2, 1'b0);
    rdb(ADDR_CAP2_HI);
    edge_stat(2, 2, BIT_CF2, 1'b0);
    rdb(ADDR_CAP2_LO);
    edge_stat(2, 2, BIT_CF2, 1'b1);
    rdb(ADDR_STATUS);
    rdb(ADDR_CAP2_LO);
    // One-pulse, then PWM: channel one stays idle, channel two still captures.
    for (int m = 0; m < 2; m++)
    begin
      wrb(ADDR_CTRL_TWO, 32'h1 << (BIT_OPM + m));
      edge_stat(1, 2, BIT_CF1, 1'b0);
      edge_stat(2, 2, BIT_CF2, 1'b1);
      rdb(ADDR_STATUS);
      rdb(ADDR_CAP2_LO);
    end
    // Reset in mid-run: count and overflow flag come back to their reset values.
    halt_mode <= 1'b0;
    repeat (10) @(posedge pclk);
    halt_mode <= 1'b1;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd16(ADDR_CNT_HI);
    chk(v, COUNT_RELOAD);
    stat(BIT_OVF, 1'b0);
    end_sim();
  end
endmodule // tb_top
